// ==== verilog/t16wm_pkg.sv ====
// Package: register map, field positions, modes and TOP constants
`default_nettype none
package t16wm_pkg;
	localparam logic [7:0] ADDR_CTRL_A = 8'h80;
	localparam logic [7:0] ADDR_CTRL_B = 8'h81;
	localparam logic [7:0] ADDR_CMP_A_LO = 8'h88;
	localparam logic [7:0] ADDR_CMP_A_HI = 8'h89;
	localparam logic [7:0] ADDR_CMP_B_LO = 8'h8A;
	localparam logic [7:0] ADDR_CMP_B_HI = 8'h8B;
	localparam logic [7:0] ADDR_CAP_LO = 8'h86;
	localparam logic [7:0] ADDR_CAP_HI = 8'h87;
	localparam logic [7:0] ADDR_CNT_LO = 8'h84;
	localparam logic [7:0] ADDR_CNT_HI = 8'h85;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h36;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h6F;
	localparam logic [7:0] ADDR_PIN_DIR = 8'h90;
	localparam int POS_MODE_A = 6;
	localparam int POS_MODE_B = 4;
	localparam int POS_WGM_LO = 0;
	localparam int POS_WGM_HI = 3;
	localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
	localparam logic [7:0] CTRL_B_WMASK = 8'h18;
	localparam logic [7:0] CTRL_A_RESET = 8'h00;
	localparam logic [7:0] CTRL_B_RESET = 8'h00;
	localparam int IRQ_OVF = 0;
	localparam int IRQ_CMP_A = 1;
	localparam int IRQ_CMP_B = 2;
	localparam logic [15:0] TOP_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [15:0] BOTTOM = 16'h0000;
	localparam logic [3:0] WGM_NORMAL = 4'h0;
	localparam logic [3:0] WGM_CTC_CMP = 4'h4;
	localparam logic [3:0] WGM_CTC_CAP = 4'hC;
	localparam logic [3:0] WGM_RESERVED = 4'hD;
	localparam logic [3:0] WGM_PFC_CMP = 4'h9;
	localparam logic [3:0] WGM_PC_CMP = 4'hB;
	localparam logic [3:0] WGM_FAST_CAP = 4'hE;
	localparam logic [3:0] WGM_FAST_CMP = 4'hF;
	typedef enum logic [2:0] {
		KIND_NORMAL,
		KIND_CTC,
		KIND_FAST,
		KIND_PC,
		KIND_PFC,
		KIND_RSVD
	} t16wm_kind_t;
	typedef enum logic [1:0] {
		TOP_SRC_FIXED,
		TOP_SRC_CMP_A,
		TOP_SRC_CAP
	} t16wm_topsrc_t;
endpackage
`default_nettype wire

// ==== verilog/t16wm_core.sv ====
// Waveform mode decode, counter and compare output control of the 16-bit timer
// Behaviour
// - Channel A mode nonzero claims its pin
// - Channel B mode nonzero claims its pin
// - Pin driven only when direction selects output
// - Non-PWM: none, toggle, clear, set on match
// - Fast PWM: 10 non-inverting, 11 inverting
// - Fast PWM toggle A only modes 14/15
// - Dual-slope toggle A only modes 9/11
// - Dual-slope: action flips with count direction
// - Fast PWM codes 10/11: match at TOP ignored, BOTTOM acts
// - Mode from ctrl A 1:0, ctrl B 4:3
// - Normal: TOP FFFF, immediate, overflow at MAX
// - CLEAR_ON_COMPARE_MODE modes 4 and 12, immediate, MAX
// - Phase correct: fixed/variable TOP, load TOP
// - Fast PWM: load at TOP, overflow at TOP
// - PFC modes 8/9: load and overflow BOTTOM
//
// Design decision made here: the strobed register port.
`default_nettype none
module t16wm_core
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_tick,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_compare_out_a,
	output logic o_compare_out_a_oe,
	output logic o_compare_out_b,
	output logic o_compare_out_b_oe,
	output logic o_irq
);
	import t16wm_pkg::*;

	logic [7:0] timer_ctrl_a;
	logic [7:0] timer_ctrl_b;
	logic [15:0] compare_value_a;
	logic [15:0] compare_value_b;
	logic [15:0] cmp_buf_a;
	logic [15:0] cmp_buf_b;
	logic [15:0] capture_value;
	logic [15:0] counter_value;
	logic [7:0] wr_hi_temp;
	logic [1:0] pin_dir;
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic count_down;
	logic wave_a;
	logic wave_b;
	logic [3:0] waveform_mode;
	logic [1:0] chan_a_output_mode;
	logic [1:0] chan_b_output_mode;
	t16wm_kind_t kind;
	t16wm_topsrc_t top_src;
	logic [15:0] top_val;
	logic [15:0] next_counter;
	logic next_down;
	logic at_top;
	logic at_bottom;
	logic match_a;
	logic match_b;
	logic load_now;
	logic overflow_evt;
	logic immediate;
	logic toggle_ok_a;
	logic top_match_a;
	logic top_match_b;
	logic wr_cmp_a;
	logic wr_cmp_b;
	logic wr_cnt;
	logic [2:0] stat_clr;
	logic [2:0] stat_set;

	// Fixed TOP from the low mode bits; zero keeps the full range
	function automatic logic [15:0] fixed_top(input logic [1:0] lo);
		case (lo)
			2'h1: fixed_top = TOP_8BIT;
			2'h2: fixed_top = TOP_9BIT;
			2'h3: fixed_top = TOP_10BIT;
			default: fixed_top = TOP_MAX;
		endcase
	endfunction

	// Next pin level for one channel; toggle_ok gates code 01 in the PWM kinds, not in normal or CTC
	function automatic logic wave_next(input logic cur, input logic [1:0] code,
			input t16wm_kind_t k, input logic match, input logic bottom,
			input logic top_match, input logic down, input logic toggle_ok);
		logic r;
		r = cur;
		case (k)
			KIND_NORMAL, KIND_CTC: begin
				if (match) begin
					case (code)
						2'h1: r = ~cur;
						2'h2: r = 1'b0;
						2'h3: r = 1'b1;
						default: r = cur;
					endcase
				end
			end
			KIND_FAST: begin
				if (code == 2'h1) begin
					if (match && toggle_ok) begin
						r = ~cur;
					end
				end else if (code[1]) begin
					if (bottom) begin
						r = ~code[0];
					end else if (match && !top_match) begin
						r = code[0];
					end
				end
			end
			KIND_PC, KIND_PFC: begin
				if (match) begin
					if (code == 2'h1) begin
						if (toggle_ok) begin
							r = ~cur;
						end
					end else if (code[1]) begin
						r = down ? ~code[0] : code[0];
					end
				end
			end
			default: r = cur;
		endcase
		return r;
	endfunction

	assign waveform_mode = {timer_ctrl_b[POS_WGM_HI+1:POS_WGM_HI], timer_ctrl_a[1:0]};
	assign chan_a_output_mode = timer_ctrl_a[POS_MODE_A+1:POS_MODE_A];
	assign chan_b_output_mode = timer_ctrl_a[POS_MODE_B+1:POS_MODE_B];

	always_comb begin
		kind = KIND_RSVD;
		top_src = TOP_SRC_FIXED;
		case (waveform_mode)
			WGM_NORMAL: kind = KIND_NORMAL;
			4'h1, 4'h2, 4'h3: kind = KIND_PC;
			WGM_CTC_CMP: begin
				kind = KIND_CTC;
				top_src = TOP_SRC_CMP_A;
			end
			4'h5, 4'h6, 4'h7: kind = KIND_FAST;
			4'h8: begin
				kind = KIND_PFC;
				top_src = TOP_SRC_CAP;
			end
			WGM_PFC_CMP: begin
				kind = KIND_PFC;
				top_src = TOP_SRC_CMP_A;
			end
			4'hA: begin
				kind = KIND_PC;
				top_src = TOP_SRC_CAP;
			end
			WGM_PC_CMP: begin
				kind = KIND_PC;
				top_src = TOP_SRC_CMP_A;
			end
			WGM_CTC_CAP: begin
				kind = KIND_CTC;
				top_src = TOP_SRC_CAP;
			end
			WGM_FAST_CAP: begin
				kind = KIND_FAST;
				top_src = TOP_SRC_CAP;
			end
			WGM_FAST_CMP: begin
				kind = KIND_FAST;
				top_src = TOP_SRC_CMP_A;
			end
			default: kind = KIND_RSVD;
		endcase
	end

	// TOP from a register follows the active value, not the buffer
	always_comb begin
		case (top_src)
			TOP_SRC_CMP_A: top_val = compare_value_a;
			TOP_SRC_CAP: top_val = capture_value;
			default: top_val = (kind == KIND_NORMAL) ? TOP_MAX : fixed_top(waveform_mode[1:0]);
		endcase
	end

	assign at_top = (counter_value == top_val);
	assign at_bottom = (counter_value == BOTTOM);
	assign match_a = i_tick && (counter_value == compare_value_a);
	assign match_b = i_tick && (counter_value == compare_value_b);
	assign immediate = (kind == KIND_NORMAL) || (kind == KIND_CTC);

	// Among the PWM modes, code 01 toggle exists for channel A in modes 9, 11, 14 and 15 only
	assign toggle_ok_a = (waveform_mode == WGM_FAST_CAP) || (waveform_mode == WGM_FAST_CMP)
		|| (waveform_mode == WGM_PFC_CMP) || (waveform_mode == WGM_PC_CMP);
	// Compare value at TOP gives no set or clear action in fast PWM; code 01 toggle still acts on it
	assign top_match_a = (compare_value_a == top_val);
	assign top_match_b = (compare_value_b == top_val);
	assign wr_cmp_a = i_wr && (i_addr == ADDR_CMP_A_LO);
	assign wr_cmp_b = i_wr && (i_addr == ADDR_CMP_B_LO);
	assign wr_cnt = i_wr && (i_addr == ADDR_CNT_LO);
	// Clear mask is zero unless this cycle writes the status byte
	assign stat_clr = (i_wr && (i_addr == ADDR_IRQ_STAT)) ? i_wdata[2:0] : 3'h0;
	assign stat_set = {match_b, match_a, i_tick && overflow_evt};

	// Dual slope turns at TOP and BOTTOM, each shown for one tick
	always_comb begin
		next_counter = counter_value;
		next_down = count_down;
		load_now = 1'b0;
		overflow_evt = 1'b0;
		case (kind)
			KIND_NORMAL, KIND_CTC: begin
				next_down = 1'b0;
				overflow_evt = (counter_value == TOP_MAX);
				next_counter = (kind == KIND_CTC && at_top) ? BOTTOM : counter_value + 16'h0001;
			end
			KIND_FAST: begin
				next_down = 1'b0;
				overflow_evt = at_top;
				load_now = at_top;
				next_counter = at_top ? BOTTOM : counter_value + 16'h0001;
			end
			KIND_PC, KIND_PFC: begin
				load_now = (kind == KIND_PC) ? at_top : at_bottom;
				overflow_evt = at_bottom && count_down;
				if (at_top) begin
					next_down = 1'b1;
				end else if (at_bottom) begin
					next_down = 1'b0;
				end
				next_counter = next_down ? counter_value - 16'h0001 : counter_value + 16'h0001;
			end
			default: next_counter = counter_value;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			timer_ctrl_a <= CTRL_A_RESET;
			timer_ctrl_b <= CTRL_B_RESET;
			pin_dir <= 2'h0;
			irq_mask <= 3'h0;
			capture_value <= 16'h0000;
			wr_hi_temp <= 8'h00;
		end else if (i_wr) begin
			case (i_addr)
				ADDR_CTRL_A: timer_ctrl_a <= i_wdata & CTRL_A_WMASK;
				ADDR_CTRL_B: timer_ctrl_b <= i_wdata & CTRL_B_WMASK;
				ADDR_PIN_DIR: pin_dir <= i_wdata[1:0];
				ADDR_IRQ_MASK: irq_mask <= i_wdata[2:0];
				ADDR_CAP_LO: capture_value <= {wr_hi_temp, i_wdata};
				ADDR_CMP_A_HI, ADDR_CMP_B_HI, ADDR_CAP_HI, ADDR_CNT_HI: wr_hi_temp <= i_wdata;
				default: wr_hi_temp <= wr_hi_temp;
			endcase
		end
	end

	// Buffers always take writes; active value follows per mode
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmp_buf_a <= 16'h0000;
			cmp_buf_b <= 16'h0000;
		end else if (wr_cmp_a) begin
			cmp_buf_a <= {wr_hi_temp, i_wdata};
		end else if (wr_cmp_b) begin
			cmp_buf_b <= {wr_hi_temp, i_wdata};
		end
	end

	// Immediate modes copy every cycle, so a write shows one cycle later
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			compare_value_a <= 16'h0000;
			compare_value_b <= 16'h0000;
		end else if (immediate) begin
			compare_value_a <= cmp_buf_a;
			compare_value_b <= cmp_buf_b;
		end else if (i_tick && load_now) begin
			compare_value_a <= cmp_buf_a;
			compare_value_b <= cmp_buf_b;
		end
	end

	// Software write to the counter wins over counting
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			counter_value <= 16'h0000;
			count_down <= 1'b0;
		end else if (wr_cnt) begin
			counter_value <= {wr_hi_temp, i_wdata};
		end else if (i_tick) begin
			counter_value <= next_counter;
			count_down <= next_down;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wave_a <= 1'b0;
			wave_b <= 1'b0;
		end else if (i_tick) begin
			wave_a <= wave_next(wave_a, chan_a_output_mode, kind, match_a, at_bottom,
				top_match_a, count_down, toggle_ok_a);
			wave_b <= wave_next(wave_b, chan_b_output_mode, kind, match_b, at_bottom,
				top_match_b, count_down, 1'b0);
		end
	end

	// Pin enable needs both a claiming mode and output direction
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_compare_out_a <= 1'b0;
			o_compare_out_b <= 1'b0;
			o_compare_out_a_oe <= 1'b0;
			o_compare_out_b_oe <= 1'b0;
		end else begin
			o_compare_out_a <= wave_a;
			o_compare_out_b <= wave_b;
			o_compare_out_a_oe <= (|chan_a_output_mode) && pin_dir[0];
			o_compare_out_b_oe <= (|chan_b_output_mode) && pin_dir[1];
		end
	end

	// Set wins over write-one-to-clear
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_stat <= 3'h0;
		end else begin
			irq_stat <= (irq_stat & ~stat_clr) | stat_set;
		end
	end

	// Level output, one cycle behind the status bits
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(irq_stat & irq_mask);
		end
	end

	// Read data stand one cycle, zero otherwise, so a bus OR stays clean
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				ADDR_CTRL_A: o_rdata <= timer_ctrl_a;
				ADDR_CTRL_B: o_rdata <= timer_ctrl_b;
				ADDR_PIN_DIR: o_rdata <= {6'h00, pin_dir};
				ADDR_IRQ_MASK: o_rdata <= {5'h00, irq_mask};
				ADDR_IRQ_STAT: o_rdata <= {5'h00, irq_stat};
				ADDR_CNT_LO: o_rdata <= counter_value[7:0];
				ADDR_CNT_HI: o_rdata <= counter_value[15:8];
				ADDR_CAP_LO: o_rdata <= capture_value[7:0];
				ADDR_CAP_HI: o_rdata <= capture_value[15:8];
				ADDR_CMP_A_LO: o_rdata <= compare_value_a[7:0];
				ADDR_CMP_A_HI: o_rdata <= compare_value_a[15:8];
				ADDR_CMP_B_LO: o_rdata <= compare_value_b[7:0];
				ADDR_CMP_B_HI: o_rdata <= compare_value_b[15:8];
				default: o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ==== bench/t16wm_props.sv ====
// Port checker for the timer waveform mode block
`default_nettype none
module t16wm_props
	import t16wm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_tick,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_compare_out_a,
	input wire logic o_compare_out_a_oe,
	input wire logic o_compare_out_b,
	input wire logic o_compare_out_b_oe,
	input wire logic o_irq
);
	logic [7:0] sh_a;
	logic [7:0] sh_b;
	logic [1:0] sh_dir;
	logic [2:0] sh_mask;
	logic [3:0] wgm;
	assign wgm = {sh_b[4:3], sh_a[1:0]};
	// Shadow of software writes, so outputs are judged against intent
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sh_a <= 8'h00;
			sh_b <= 8'h00;
			sh_dir <= 2'h0;
			sh_mask <= 3'h0;
		end else if (i_wr) begin
			case (i_addr)
				ADDR_CTRL_A: sh_a <= i_wdata & CTRL_A_WMASK;
				ADDR_CTRL_B: sh_b <= i_wdata & CTRL_B_WMASK;
				ADDR_PIN_DIR: sh_dir <= i_wdata[1:0];
				ADDR_IRQ_MASK: sh_mask <= i_wdata[2:0];
				default: ;
			endcase
		end
	end
	default clocking dc @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data not idle");
	a_ctrl_a_read: assert property ($past(i_rd && i_addr == ADDR_CTRL_A) |->
		o_rdata == $past(sh_a)) else $error("ctrl a readback wrong");
	a_ctrl_b_read: assert property ($past(i_rd && i_addr == ADDR_CTRL_B) |->
		o_rdata == $past(sh_b)) else $error("ctrl b readback wrong");
	a_unmapped_rd: assert property ($past(i_rd && i_addr == 8'h00) |-> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_pin_a_claim: assert property (o_compare_out_a_oe ==
		$past(sh_a[7:6] != 2'b00 && sh_dir[0])) else $error("pin a enable wrong");
	a_pin_b_claim: assert property (o_compare_out_b_oe ==
		$past(sh_a[5:4] != 2'b00 && sh_dir[1])) else $error("pin b enable wrong");
	a_irq_masked: assert property (o_irq |-> $past(sh_mask) != 3'h0)
		else $error("irq with all masked");
	a_rsvd_hold: assert property ($past(wgm, 2) == WGM_RESERVED &&
		$past(wgm, 3) == WGM_RESERVED |-> $stable(o_compare_out_a) && $stable(o_compare_out_b))
		else $error("outputs move in reserved mode");
endmodule
bind t16wm_core t16wm_props u_props (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
	.i_tick(i_tick), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .o_compare_out_a(o_compare_out_a),
	.o_compare_out_a_oe(o_compare_out_a_oe), .o_compare_out_b(o_compare_out_b),
	.o_compare_out_b_oe(o_compare_out_b_oe), .o_irq(o_irq));
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the timer waveform mode block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import t16wm_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_tick = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] o_rdata;
	logic oa, oa_oe, ob, ob_oe, o_irq;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int n;
	int pm[6] = '{1, 2, 3, 5, 6, 7};
	int pe[6] = '{510, 1022, 2046, 256, 512, 1024};
	int tm[6] = '{4, 12, 14, 15, 9, 11};
	int te[6] = '{20, 20, 20, 20, 36, 36};
	t16wm_core DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_tick(i_tick),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_compare_out_a(oa), .o_compare_out_a_oe(oa_oe), .o_compare_out_b(ob),
		.o_compare_out_b_oe(ob_oe), .o_irq(o_irq));
	initial begin
		forever #50 i_sys_clk = ~i_sys_clk;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Ceiling well above the roughly 18k cycles the tests need
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic chkc(input int g, input int e);
		n_checks++;
		if (g != e) begin
			num_errors++;
			$display("BAD %0t count %0d want %0d", $time, g, e);
		end
	endtask
	// Idle cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		@(posedge i_sys_clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 chk8(o_rdata, e);
		@(posedge i_sys_clk);
	endtask
	task automatic w16(input logic [7:0] a, input logic [15:0] v);
		wr(a + 8'h01, v[15:8]);
		wr(a, v[7:0]);
	endtask
	task automatic pins(input logic [7:0] e);
		#1 chk8({6'h00, oa_oe, ob_oe}, e);
		@(posedge i_sys_clk);
	endtask
	// Counter is parked at zero with ticks off so no mode starts past its TOP
	task automatic cfg(input int m, input logic [1:0] ca, input logic [1:0] cb,
		input logic [15:0] va, input logic [15:0] vb);
		i_tick <= 1'b0;
		wr(ADDR_CTRL_A, 8'h00);
		wr(ADDR_CTRL_B, 8'h00);
		w16(ADDR_CMP_A_LO, va);
		w16(ADDR_CMP_B_LO, vb);
		w16(ADDR_CAP_LO, va);
		w16(ADDR_CNT_LO, 16'h0000);
		wr(ADDR_CTRL_B, {3'b000, 2'(m >> 2), 3'b000});
		wr(ADDR_CTRL_A, {ca, cb, 2'b00, 2'(m)});
		i_tick <= 1'b1;
	endtask
	// Rising-to-rising distance, skipping the first period after setup
	task automatic per(input int e);
		logic p, c;
		int t, k, t0;
		p = 1'b1;
		t = 0;
		k = 0;
		t0 = 0;
		while (k < 3 && t < 7000) begin
			@(posedge i_sys_clk);
			#1 c = oa;
			t++;
			if (c === 1'b1 && p === 1'b0) begin
				k++;
				if (k == 2)
					t0 = t;
			end
			p = c;
		end
		chkc(t - t0, e);
	endtask
	initial begin
		repeat (16) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		@(posedge i_sys_clk);
		rchk(ADDR_CTRL_A, 8'h00);
		wr(ADDR_CTRL_A, 8'hFF);
		rchk(ADDR_CTRL_A, 8'hF3);
		wr(ADDR_CTRL_B, 8'hFF);
		rchk(ADDR_CTRL_B, 8'h18);
		rchk(8'h00, 8'h00);
		pins(8'h00);
		wr(ADDR_PIN_DIR, 8'h03);
		pins(8'h03);
		wr(ADDR_CTRL_A, 8'h40);
		pins(8'h02);
		wr(ADDR_CTRL_A, 8'h10);
		pins(8'h01);
		$display("registers and pins done");
		for (int i = 0; i < 6; i++) begin
			cfg(pm[i], 2'b10, 2'b11, 16'h0040, 16'h0040);
			per(pe[i]);
			#1 chk8({7'h00, oa ^ ob}, 8'h01);
			@(posedge i_sys_clk);
		end
		for (int i = 0; i < 6; i++) begin
			cfg(tm[i], 2'b01, 2'b01, 16'h0009, 16'h0003);
			per(te[i]);
			@(posedge i_sys_clk);
		end
		$display("periods done");
		cfg(5, 2'b10, 2'b11, 16'h00FF, 16'h0040);
		repeat (300) @(posedge i_sys_clk);
		n = 0;
		#1;
		repeat (300) #100 n += (oa !== 1'b1);
		chkc(n, 0);
		@(posedge i_sys_clk);
		cfg(13, 2'b10, 2'b11, 16'h0040, 16'h0040);
		repeat (60) @(posedge i_sys_clk);
		#1 chk8({7'h00, oa}, 8'h01);
		@(posedge i_sys_clk);
		rchk(ADDR_CNT_LO, 8'h00);
		$display("top match and reserved done");
		cfg(0, 2'b00, 2'b00, 16'h1000, 16'h1000);
		@(posedge i_sys_clk);
		i_tick <= 1'b0;
		w16(ADDR_CNT_LO, 16'hFFF0);
		wr(ADDR_IRQ_STAT, 8'h07);
		wr(ADDR_IRQ_MASK, 8'h01);
		i_tick <= 1'b1;
		repeat (10) @(posedge i_sys_clk);
		#1 chk8({7'h00, o_irq}, 8'h00);
		repeat (20) @(posedge i_sys_clk);
		#1 chk8({7'h00, o_irq}, 8'h01);
		@(posedge i_sys_clk);
		i_tick <= 1'b0;
		rchk(ADDR_IRQ_STAT, 8'h01);
		wr(ADDR_IRQ_STAT, 8'h07);
		rchk(ADDR_IRQ_STAT, 8'h00);
		#1 chk8({7'h00, o_irq}, 8'h00);
		@(posedge i_sys_clk);
		wr(ADDR_IRQ_MASK, 8'h00);
		$display("overflow and interrupt done");
		close_out();
	end
endmodule
`default_nettype wire
